/* shared/msp_pkg.sv */
`default_nettype none
package msp_pkg;
	// Register byte offsets
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_COUNT  = 5'h04;
	localparam logic [4:0] OFF_DIV    = 5'h08;
	localparam logic [4:0] OFF_CMD    = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_TXDATA = 5'h14;
	localparam logic [4:0] OFF_RXDATA = 5'h18;
	// Command bits, write-one actions
	localparam int CMD_START   = 0;
	localparam int CMD_STOP    = 1;
	localparam int CMD_FLAGCLR = 2;
	// Count register fields
	localparam int CNT_START_LSB = 0;
	localparam int CNT_STOP_LSB  = 4;
	// Status register fields
	localparam int ST_CLK_ACTIVE = 0;
	localparam int ST_TWO_WIRE   = 1;
	localparam int ST_RX_FLAG    = 2;
	localparam int ST_CNT_LSB    = 4;
	// Mode encodings {modeSelHigh, modeSelLow}
	localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
	localparam logic [1:0] MODE_TWO_WIRE   = 2'h1;
	localparam logic [1:0] MODE_UART       = 2'h2;
	// Sizes and reset values
	localparam int DATA_W = 16;
	localparam logic [11:0] CTRL_RESET  = 12'h000;
	localparam logic [3:0]  START_RESET = 4'h0;
	localparam logic [3:0]  STOP_RESET  = 4'h8;
	localparam logic [7:0]  DIV_RESET   = 8'h04;
	localparam logic [15:0] DATA_RESET  = 16'h0000;
	// Serial interrupt vector address
	localparam logic [12:0] IRQ_VECTOR = 13'h0001;
	// Quarter-period phases of one serial clock
	localparam logic [1:0] PH_LEAD  = 2'h0;
	localparam logic [1:0] PH_MID   = 2'h1;
	localparam logic [1:0] PH_TRAIL = 2'h2;
	localparam logic [1:0] PH_LAST  = 2'h3;
	// Configuration word
	typedef struct packed {
		logic irqEnable;
		logic serialPinEnable;
		logic stopWaitEnable;
		logic inputPinSel;
		logic pinPairSel;
		logic dataDirectionSel;
		logic msbFirst;
		logic openDrainSel;
		logic clockPolaritySel;
		logic master;
		logic modeSelHigh;
		logic modeSelLow;
	} msp_cfg_s;
	// One pin as two signals
	typedef struct packed {
		logic out;
		logic oeN;
	} msp_pin_s;
	typedef enum {S_IDLE, S_STARTC, S_RUN, S_WAIT, S_STOPC} msp_state_e;
	typedef enum {T_IDLE, T_START, T_BITS, T_LAST} msp_txstate_e;
	typedef enum {R_IDLE, R_START, R_BITS} msp_rxstate_e;
endpackage : msp_pkg
`default_nettype wire

/* design/msp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module msp_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rstN,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] stage1_q;

	// Two-flop synchroniser, first stage read only by second
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			stage1_q <= '0;
			syncOut  <= '0;
		end else begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end
endmodule : msp_sync
`default_nettype wire

/* design/msp_baud.sv */
`timescale 1ns/1ps
`default_nettype none
module msp_baud (
	input  wire logic       ref_clk,
	input  wire logic       rstN,
	input  wire logic       enable,
	input  wire logic [7:0] divider,
	output logic            tick,
	output logic      [1:0] phase
);
	logic [7:0] cnt_q;
	logic [1:0] ph_q;
	logic       wrap;

	// One tick per quarter serial clock, divider+1 ref cycles
	assign wrap  = enable && (cnt_q >= divider);
	assign tick  = wrap;
	assign phase = ph_q;

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			cnt_q <= 8'h00;
			ph_q  <= 2'h0;
		end else if (!enable) begin
			cnt_q <= 8'h00;
			ph_q  <= 2'h0;
		end else if (wrap) begin
			cnt_q <= 8'h00;
			ph_q  <= ph_q + 2'h1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule : msp_baud
`default_nettype wire

/* design/msp_top.sv */
// Contract
// - Polarity clear: clock idles low, data changes rising, sampled falling.
// - Polarity set: clock idles high, data changes falling, sampled rising.
// - Driver select set gives open-drain outputs, cleared gives push-pull.
// - Bit order set sends MSB first, cleared sends LSB first.
// - Direction set drives data pin except in UART; cleared leaves it an input but for two-wire start and stop.
// - Pair select cleared uses CMOS pins, set uses open-drain pins.
// - Input select cleared takes serial input or UART receive from data pin.
// - Stop-wait enable parks the port at the stop position until released.
// - Master set generates the serial clock; cleared follows external clock.
// - No start while two-wire busy in master mode; stop must come first.
// - Receive pulse at most a quarter clock period cancels reception start.
// - UART takes three samples per bit and keeps the majority.
// - Ninth transmit bit is the stop bit, or data bit 8 when the stop count is nine.
// - UART transmit and receive run together in full duplex.
// - Interrupt when either direction ends and clock busy drops to zero.
// - Interrupt on falling edge of clock busy, vector address one.
// - Receive flag set on slave or UART reception, cleared by flag clear.
`timescale 1ns/1ps
`default_nettype none
module msp_top (
	input  wire logic                     ref_clk,
	input  wire logic                     reset_n,
	input  wire logic [4:0]               avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	input  wire logic                     cmosDataIn,
	output msp_pkg::msp_pin_s             cmosDataPin,
	input  wire logic                     cmosClockIn,
	output msp_pkg::msp_pin_s             cmosClockPin,
	input  wire logic                     odDataIn,
	output msp_pkg::msp_pin_s             odDataPin,
	input  wire logic                     odClockIn,
	output msp_pkg::msp_pin_s             odClockPin,
	input  wire logic                     serialInPin,
	output logic                          serialIrq,
	output logic      [12:0]              irqVector
);
	import msp_pkg::*;

	logic [1:0]        rstPipe_q;
	logic              rstN;
	msp_cfg_s          cfg_q;
	logic [3:0]        start_q;
	logic [3:0]        stop_q;
	logic [7:0]        div_q;
	logic [15:0]       txData_q;
	logic [15:0]       rxData_q;
	logic              rxFlag_q;
	logic              ack_q;
	logic [31:0]       readdata_q;
	msp_state_e        state_q;
	logic [3:0]        cnt_q;
	logic              dataLine_q;
	logic              sckLine_q;
	msp_txstate_e      tstate_q;
	logic [3:0]        tcnt_q;
	logic              txLine_q;
	msp_rxstate_e      rstate_q;
	logic [3:0]        rcnt_q;
	logic [1:0]        rq_q;
	logic [1:0]        votes_q;
	logic              sclkPrev_q;
	logic              clkActPrev_q;
	logic              irq_q;
	logic [4:0]        pinSync;
	logic              tick;
	logic [1:0]        phase;

	// Mirror a frame position when sending MSB first
	function automatic logic [3:0] bitPos(input logic [3:0] c, input logic [3:0] s,
		input logic [3:0] e, input logic msb);
		logic [4:0] m;
		m = {1'b0, s} + {1'b0, e} - 5'h01 - {1'b0, c};
		return msb ? m[3:0] : c;
	endfunction : bitPos

	// Pin driver: open-drain pulls low only, push-pull drives both levels
	function automatic msp_pin_s pinDrive(input logic drive, input logic val,
		input logic od);
		msp_pin_s p;
		p.out = od ? 1'b0 : val;
		p.oeN = ~(drive & (~od | ~val));
		return p;
	endfunction : pinDrive

	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe_q <= 2'b00;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstN = rstPipe_q[1];

	// Pin inputs: {serialIn, odClock, odData, cmosClock, cmosData}
	msp_sync #(.W(5)) u_sync (
		.ref_clk (ref_clk),
		.rstN    (rstN),
		.asyncIn ({serialInPin, odClockIn, odDataIn, cmosClockIn, cmosDataIn}),
		.syncOut (pinSync)
	);

	// Quarter-period tick source for master clock and UART
	msp_baud u_baud (
		.ref_clk (ref_clk),
		.rstN    (rstN),
		.enable  (cfg_q.serialPinEnable),
		.divider (div_q),
		.tick    (tick),
		.phase   (phase)
	);

	// Mode and bus decode
	wire [1:0] mode     = {cfg_q.modeSelHigh, cfg_q.modeSelLow};
	wire       isUart   = (mode == MODE_UART);
	wire       isTwo    = (mode == MODE_TWO_WIRE);
	wire       access   = avs_read | avs_write;
	wire       wrDone   = avs_write & ack_q;
	wire       selCtrl  = (avs_address == OFF_CTRL);
	wire       selCount = (avs_address == OFF_COUNT);
	wire       selDiv   = (avs_address == OFF_DIV);
	wire       selCmd   = (avs_address == OFF_CMD);
	wire       selStat  = (avs_address == OFF_STATUS);
	wire       selTx    = (avs_address == OFF_TXDATA);
	wire       selRx    = (avs_address == OFF_RXDATA);
	wire       cmdWr    = wrDone & selCmd;
	wire       cmdStart = cmdWr & avs_writedata[CMD_START];
	wire       cmdStop  = cmdWr & avs_writedata[CMD_STOP];
	wire       cmdClr   = cmdWr & avs_writedata[CMD_FLAGCLR];

	// Input pin choice by pair, then serial input choice
	wire dataIn  = cfg_q.pinPairSel ? pinSync[2] : pinSync[0];
	wire clkIn   = cfg_q.pinPairSel ? pinSync[3] : pinSync[1];
	wire serIn   = cfg_q.inputPinSel ? pinSync[4] : dataIn;

	// Edge events: lead launches data, trail samples it
	wire idleLvl   = cfg_q.clockPolaritySel;
	wire sclkChg   = (clkIn != sclkPrev_q);
	wire mLead     = tick & (phase == PH_LEAD);
	wire mTrail    = tick & (phase == PH_TRAIL);
	wire sLead     = sclkChg & (clkIn != idleLvl);
	wire sTrail    = sclkChg & (clkIn == idleLvl);
	wire leadEv    = cfg_q.master ? mLead : sLead;
	// A master trailing edge counts only after its own leading edge
	wire trailEv   = cfg_q.master ? (mTrail & (sckLine_q != idleLvl)) : sTrail;

	// Counter positions and frame ends
	wire [3:0] engPos  = bitPos(cnt_q, start_q, stop_q, cfg_q.msbFirst);
	wire [3:0] txPos   = bitPos(tcnt_q, start_q, stop_q, cfg_q.msbFirst);
	wire [3:0] firstPos = bitPos(start_q, start_q, stop_q, cfg_q.msbFirst);
	wire [3:0] cntNext = cnt_q + 4'h1;
	wire       engCap  = (state_q == S_RUN) & trailEv;
	wire       engDone = engCap & (cntNext == stop_q);
	wire       uTick   = tick & isUart;
	wire       voteBit = (votes_q[0] & votes_q[1]) | (votes_q[0] & serIn)
		| (votes_q[1] & serIn);
	wire       uCap    = (rstate_q == R_BITS) & uTick & (rq_q == PH_LAST);
	wire       uDone   = uCap & ((rcnt_q + 4'h1) == stop_q);
	wire [3:0] rxPos   = bitPos(rcnt_q, start_q, stop_q, cfg_q.msbFirst);

	// Activity flags
	wire engBusy    = (state_q == S_RUN) | (state_q == S_STARTC) | (state_q == S_STOPC);
	wire uTxBusy    = (tstate_q != T_IDLE);
	wire uRxBusy    = (rstate_q != R_IDLE);
	wire clkActive  = engBusy | uTxBusy | uRxBusy;
	wire twoWireAct = isTwo ? (state_q != S_IDLE) : (isUart & uRxBusy);
	wire cfgLocked  = clkActive | (state_q == S_WAIT);
	wire startOk    = cmdStart & cfg_q.master & ~isUart
		& ~(isTwo & twoWireAct);

	// Bus handshake: one wait cycle, then the answer
	assign avs_waitrequest = access & ~ack_q;
	assign avs_readdata    = readdata_q;
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= access & ~ack_q;
		end
	end

	// Read mux, latched in the wait cycle
	wire [31:0] statWord = {24'h000000, cnt_q, 1'b0, rxFlag_q, twoWireAct, clkActive};
	wire [31:0] rdMux =
		selCtrl  ? {20'h00000, cfg_q} :
		selCount ? {24'h000000, stop_q, start_q} :
		selDiv   ? {24'h000000, div_q} :
		selStat  ? statWord :
		selTx    ? {16'h0000, txData_q} :
		selRx    ? {16'h0000, rxData_q} : 32'h00000000;
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			readdata_q <= 32'h00000000;
		end else if (avs_read & ~ack_q) begin
			readdata_q <= rdMux;
		end
	end

	// Configuration writes, ignored during a transfer
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			cfg_q    <= msp_cfg_s'(CTRL_RESET);
			start_q  <= START_RESET;
			stop_q   <= STOP_RESET;
			div_q    <= DIV_RESET;
			txData_q <= DATA_RESET;
		end else if (wrDone & ~cfgLocked) begin
			if (selCtrl) cfg_q <= msp_cfg_s'(avs_writedata[11:0]);
			if (selCount) start_q <= avs_writedata[CNT_START_LSB +: 4];
			if (selCount) stop_q <= avs_writedata[CNT_STOP_LSB +: 4];
			if (selDiv) div_q <= avs_writedata[7:0];
			if (selTx) txData_q <= avs_writedata[15:0];
		end
	end

	// Three-wire and two-wire engine
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			state_q    <= S_IDLE;
			cnt_q      <= START_RESET;
			dataLine_q <= 1'b1;
			sckLine_q  <= 1'b0;
			sclkPrev_q <= 1'b0;
		end else begin
			sclkPrev_q <= clkIn;
			if (cmdStop) begin
				cnt_q <= stop_q;
				sckLine_q <= idleLvl;
				if (cfg_q.master & isTwo) begin
					state_q    <= S_STOPC;
					dataLine_q <= 1'b0;
				end else begin
					state_q <= S_IDLE;
				end
			end else begin
				case (state_q)
					S_IDLE: begin
						sckLine_q <= idleLvl;
						if (startOk) begin
							cnt_q   <= start_q;
							state_q <= isTwo ? S_STARTC : S_RUN;
						end else if (~cfg_q.master & ~isUart & sLead) begin
							cnt_q      <= start_q;
							dataLine_q <= txData_q[firstPos];
							state_q    <= S_RUN;
						end
					end
					S_STARTC: begin
						// Data falls while the clock rests at its idle level
						if (mTrail) dataLine_q <= 1'b0;
						if (tick & (phase == PH_LAST)) state_q <= S_RUN;
					end
					S_RUN: begin
						if (leadEv) begin
							dataLine_q <= txData_q[engPos];
							if (cfg_q.master) sckLine_q <= ~idleLvl;
						end
						if (trailEv) begin
							if (cfg_q.master) sckLine_q <= idleLvl;
							cnt_q <= cntNext;
							if (engDone) begin
								state_q <= cfg_q.stopWaitEnable ? S_WAIT : S_IDLE;
							end
						end
					end
					S_WAIT: begin
						if (cmdClr) state_q <= S_IDLE;
					end
					S_STOPC: begin
						// Data rises while the clock rests at its idle level
						if (mTrail) begin
							dataLine_q <= 1'b1;
							state_q    <= S_IDLE;
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	// UART transmitter, runs beside the receiver
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			tstate_q <= T_IDLE;
			tcnt_q   <= START_RESET;
			txLine_q <= 1'b1;
		end else if (cmdStop) begin
			tstate_q <= T_IDLE;
			txLine_q <= 1'b1;
		end else begin
			case (tstate_q)
				T_IDLE: begin
					if (cmdStart & isUart) tstate_q <= T_START;
				end
				T_START: begin
					if (uTick & (phase == PH_LEAD)) begin
						txLine_q <= 1'b0;
						tcnt_q   <= start_q;
						tstate_q <= T_BITS;
					end
				end
				T_BITS: begin
					if (uTick & (phase == PH_LEAD)) begin
						txLine_q <= txData_q[txPos];
						tcnt_q   <= tcnt_q + 4'h1;
						if ((tcnt_q + 4'h1) == stop_q) tstate_q <= T_LAST;
					end
				end
				T_LAST: begin
					if (uTick & (phase == PH_LEAD)) begin
						txLine_q <= 1'b1;
						tstate_q <= T_IDLE;
					end
				end
				default: tstate_q <= T_IDLE;
			endcase
		end
	end

	// UART receiver with glitch reject and majority vote
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rstate_q <= R_IDLE;
			rcnt_q   <= START_RESET;
			rq_q     <= 2'h0;
			votes_q  <= 2'b00;
		end else if (cmdStop | ~isUart) begin
			rstate_q <= R_IDLE;
		end else begin
			case (rstate_q)
				R_IDLE: begin
					rq_q <= 2'h0;
					if (~serIn) rstate_q <= R_START;
				end
				R_START: begin
					if (uTick) begin
						rq_q <= rq_q + 2'h1;
						if ((rq_q == PH_MID) & serIn) begin
							rstate_q <= R_IDLE;
						end else if (rq_q == PH_LAST) begin
							rstate_q <= R_BITS;
							rcnt_q   <= start_q;
						end
					end
				end
				R_BITS: begin
					if (uTick) begin
						rq_q <= rq_q + 2'h1;
						if (rq_q == PH_MID) votes_q[0] <= serIn;
						if (rq_q == PH_TRAIL) votes_q[1] <= serIn;
						if (uCap) rcnt_q <= rcnt_q + 4'h1;
						if (uDone) rstate_q <= R_IDLE;
					end
				end
				default: rstate_q <= R_IDLE;
			endcase
		end
	end

	// Received data store, engine or UART sample
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rxData_q <= DATA_RESET;
		end else if (engCap) begin
			rxData_q[engPos] <= serIn;
		end else if (uCap) begin
			rxData_q[rxPos] <= voteBit;
		end
	end

	// Receive flag: set wins over clear
	wire rxSet = (engDone & ~cfg_q.master) | uDone;
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rxFlag_q <= 1'b0;
		end else if (rxSet) begin
			rxFlag_q <= 1'b1;
		end else if (cmdClr) begin
			rxFlag_q <= 1'b0;
		end
	end

	// Interrupt pulse on falling edge of clock activity
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			clkActPrev_q <= 1'b0;
			irq_q        <= 1'b0;
		end else begin
			clkActPrev_q <= clkActive;
			irq_q <= cfg_q.irqEnable & clkActPrev_q & ~clkActive;
		end
	end
	assign serialIrq = irq_q;
	assign irqVector = IRQ_VECTOR;

	// Pin drive: direction gates data, pair select routes, driver type shapes
	wire pe     = cfg_q.serialPinEnable;
	wire od     = cfg_q.openDrainSel;
	wire dDrv   = pe & ~isUart & (cfg_q.dataDirectionSel | (state_q == S_STARTC)
		| (state_q == S_STOPC));
	wire cDrv   = pe & (isUart | cfg_q.master);
	wire cVal   = isUart ? txLine_q : sckLine_q;
	wire usePd  = cfg_q.pinPairSel;
	assign cmosDataPin  = pinDrive(dDrv & ~usePd, dataLine_q, od);
	assign cmosClockPin = pinDrive(cDrv & ~usePd, cVal, od);
	assign odDataPin    = pinDrive(dDrv & usePd, dataLine_q, od);
	assign odClockPin   = pinDrive(cDrv & usePd, cVal, od);
endmodule : msp_top
`default_nettype wire

/* tb/msp_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module msp_top_asserts (
	input wire logic              ref_clk,
	input wire logic              reset_n,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [4:0]        avs_address,
	input wire logic [31:0]       avs_writedata,
	input wire logic              avs_waitrequest,
	input wire msp_pkg::msp_pin_s cmosDataPin,
	input wire msp_pkg::msp_pin_s cmosClockPin,
	input wire msp_pkg::msp_pin_s odDataPin,
	input wire msp_pkg::msp_pin_s odClockPin,
	input wire logic              serialIrq,
	input wire logic [12:0]       irqVector
);
	import msp_pkg::*;
	msp_cfg_s wrCfg;
	logic     odSel_q;
	// Driver type as last written; writes refused in mid-transfer are not told apart
	assign wrCfg = msp_cfg_s'(avs_writedata[11:0]);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			odSel_q <= 1'b0;
		end else if (avs_write && !avs_waitrequest && avs_address == OFF_CTRL) begin
			odSel_q <= wrCfg.openDrainSel;
		end
	end
	// All checks on the main clock, quiet in reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wait_once_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait longer than one cycle");
	wait_first_a: assert property (
		$rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("request answered without wait");
	idle_free_a: assert property (
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait raised while idle");
	vector_one_a: assert property (
		irqVector == 13'h0001)
		else $error("wrong vector");
	irq_pulse_a: assert property (
		serialIrq |=> !serialIrq)
		else $error("interrupt wider than a cycle");
	clock_pair_a: assert property (
		!cmosClockPin.oeN |-> odClockPin.oeN)
		else $error("both clock pins driven");
	data_pair_a: assert property (
		!cmosDataPin.oeN |-> odDataPin.oeN)
		else $error("both data pins driven");
	od_low_a: assert property (
		!odClockPin.oeN && odSel_q |-> !odClockPin.out)
		else $error("open-drain pin driven high");
	// Main scenarios reached
	cover property (avs_write && !avs_waitrequest);
	cover property (serialIrq);
	cover property (!odClockPin.oeN);
endmodule : msp_top_asserts
bind msp_top msp_top_asserts i_chk (.ref_clk, .reset_n, .avs_read, .avs_write, .avs_address,
	.avs_writedata, .avs_waitrequest, .cmosDataPin, .cmosClockPin, .odDataPin, .odClockPin,
	.serialIrq, .irqVector);
`default_nettype wire

/* tb/msp_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module msp_peer #(
	parameter int BIT_NS = 80
) (
	input wire msp_pkg::msp_pin_s cmosDataPin,
	input wire msp_pkg::msp_pin_s cmosClockPin,
	input wire msp_pkg::msp_pin_s odDataPin,
	input wire msp_pkg::msp_pin_s odClockPin,
	input wire logic              clock_polarity_sel,
	output logic                  cmosDataIn,
	output logic                  cmosClockIn,
	output logic                  odDataIn,
	output logic                  odClockIn,
	output logic                  serialInPin
);
	import msp_pkg::*;
	logic       slvBit = 1'b0;
	logic       peerLow = 1'b0;
	logic       drvSeen = 1'b0;
	logic [7:0] sendByte = 8'h00;
	logic [7:0] cap = 8'h00;
	logic [8:0] uCap = 9'h000;
	int         lead = 0;
	int         trail = 0;
	// Line levels; the open-drain pair has pull-ups, an idle slave holds its clock still
	assign cmosClockIn = cmosClockPin.oeN ? clock_polarity_sel : cmosClockPin.out;
	assign cmosDataIn  = cmosDataPin.oeN ? slvBit : cmosDataPin.out;
	assign odDataIn    = !((!odDataPin.oeN && !odDataPin.out) || peerLow);
	assign odClockIn   = !(!odClockPin.oeN && !odClockPin.out);
	assign serialInPin = 1'b1;
	// Arm the slave for a new frame
	task automatic startFrame(input logic [7:0] b);
		sendByte = b;
		lead = 0;
		trail = 0;
		drvSeen = 1'b0;
		slvBit = ~b[0];
	endtask : startFrame
	// Slave: next bit on the leading edge, capture on the trailing edge
	always @(cmosClockPin.out) begin
		if (!cmosClockPin.oeN && cmosClockPin.out != clock_polarity_sel) begin
			slvBit = (lead < 8) ? sendByte[lead] : ~slvBit;
			lead++;
		end else if (!cmosClockPin.oeN && trail < 8) begin
			cap[trail] = cmosDataPin.out;
			drvSeen |= !cmosDataPin.oeN;
			trail++;
		end
	end
	// Receiver of the transmit line, centre of each bit
	initial forever begin
		@(negedge odClockIn);
		#(BIT_NS * 3 / 2);
		for (int i = 0; i < 9; i++) begin
			uCap[i] = odClockIn;
			#(BIT_NS);
		end
		wait (odClockIn);
	end
	// Sender on the receive line; noise flips an eighth of bit 3
	task automatic uartSend(input logic [7:0] b, input logic noise);
		peerLow = 1'b1;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			peerLow = !b[i];
			if (noise && i == 3) begin
				#(BIT_NS * 7 / 16);
				peerLow = b[i];
				#(BIT_NS / 8);
				peerLow = !b[i];
				#(BIT_NS * 7 / 16);
			end else
				#(BIT_NS);
		end
		peerLow = 1'b0;
		#(BIT_NS);
	endtask : uartSend
	// Low pulse narrower than a quarter bit
	task automatic uartSpike();
		peerLow = 1'b1;
		#(BIT_NS / 8);
		peerLow = 1'b0;
	endtask : uartSpike
endmodule : msp_peer
`default_nettype wire

/* tb/msp_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
	checks++; \
	if ((s) !== (e)) begin \
		fails++; \
		$display("ERROR %s expected %0h seen %0h", n, e, s); \
	end \
end
module msp_top_bench;
	import msp_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	msp_pin_s    cmosDataPin;
	msp_pin_s    cmosClockPin;
	msp_pin_s    odDataPin;
	msp_pin_s    odClockPin;
	wire logic   cmosDataIn, cmosClockIn, odDataIn, odClockIn, serialInPin;
	logic        serialIrq;
	logic [12:0] irqVector;
	logic        clock_polarity_sel = 1'b0;
	logic [31:0] q;
	logic [11:0] cfgs [3] = '{12'hC44, 12'hC6C, 12'hC24};
	logic [4:0]  ra [5] = '{OFF_CTRL, OFF_COUNT, OFF_DIV, OFF_CMD, 5'h1C};
	logic [31:0] rv [5] = '{32'h0, 32'h80, 32'h4, 32'h0, 32'h0};
	int          fails = 0;
	int          checks = 0;
	int          irqCount = 0;
	int          n0;
	// Clock and interrupt pulse counter
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (serialIrq === 1'b1) irqCount <= irqCount + 1;
	msp_top i_dut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .cmosDataIn, .cmosDataPin, .cmosClockIn, .cmosClockPin,
		.odDataIn, .odDataPin, .odClockIn, .odClockPin, .serialInPin, .serialIrq, .irqVector);
	msp_peer i_peer (.cmosDataPin, .cmosClockPin, .odDataPin, .odClockPin, .clock_polarity_sel, .cmosDataIn,
		.cmosClockIn, .odDataIn, .odClockIn, .serialInPin);
	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge ref_clk iff avs_waitrequest === 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// Read status until a bit takes a value
	task automatic poll(input int b, input logic v);
		for (int k = 0; k < 300; k++) begin
			bus(1'b0, OFF_STATUS, 32'h0);
			if (q[b] === v) break;
		end
		`CHK("status poll", v, q[b])
	endtask : poll
	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// Watchdog
	initial begin
		#50us;
		fails++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		// Reset values, command register and an unmapped place
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, ra[i], 32'h0);
			`CHK("reset value", rv[i], q)
		end
		`CHK("pin released", 1'b1, cmosClockPin.oeN)
		bus(1'b1, OFF_DIV, 32'h3);
		// Three-wire master: order, polarity and direction
		for (int c = 0; c < 3; c++) begin
			bus(1'b1, OFF_CTRL, 32'(cfgs[c]));
			bus(1'b1, OFF_COUNT, 32'h80);
			bus(1'b1, OFF_TXDATA, 32'h3A);
			clock_polarity_sel = cfgs[c][3];
			i_peer.startFrame(8'h1E);
			n0 = irqCount;
			bus(1'b1, OFF_CMD, 32'(1 << CMD_START));
			poll(ST_CLK_ACTIVE, 1'b1);
			bus(1'b1, OFF_CTRL, 32'h0);
			poll(ST_CLK_ACTIVE, 1'b0);
			bus(1'b0, OFF_CTRL, 32'h0);
			`CHK("ctrl held", cfgs[c], q[11:0])
			bus(1'b0, OFF_STATUS, 32'h0);
			`CHK("end count", 4'h8, q[7:4])
			`CHK("idle clock", clock_polarity_sel, cmosClockPin.out)
			`CHK("irq count", n0 + 1, irqCount)
			`CHK("data driven", cfgs[c][6], i_peer.drvSeen)
			if (cfgs[c][6])
				`CHK("tx bits", cfgs[c][5] ? 8'h5C : 8'h3A, i_peer.cap)
			else begin
				bus(1'b0, OFF_RXDATA, 32'h0);
				`CHK("rx bits", 8'h78, q[7:0])
			end
		end
		// Two-wire master: stop first, park at the stop position, restart refused
		bus(1'b1, OFF_CTRL, 32'hEFD);
		bus(1'b1, OFF_COUNT, 32'hE7);
		bus(1'b1, OFF_TXDATA, 32'h2A80);
		bus(1'b1, OFF_CMD, 32'(1 << CMD_STOP));
		poll(ST_CLK_ACTIVE, 1'b0);
		bus(1'b1, OFF_CMD, 32'(1 << CMD_START));
		poll(ST_CLK_ACTIVE, 1'b1);
		poll(ST_CLK_ACTIVE, 1'b0);
		`CHK("two-wire wait", 1'b1, q[ST_TWO_WIRE])
		bus(1'b1, OFF_CMD, 32'(1 << CMD_START));
		bus(1'b0, OFF_STATUS, 32'h0);
		`CHK("start refused", 1'b0, q[ST_CLK_ACTIVE])
		bus(1'b1, OFF_CMD, 32'(1 << CMD_STOP));
		poll(ST_TWO_WIRE, 1'b0);
		bus(1'b0, OFF_RXDATA, 32'h0);
		`CHK("two-wire bits", 7'h55, q[13:7])
		// UART: spike, then full duplex with one noisy sample
		bus(1'b1, OFF_CTRL, 32'hCD2);
		bus(1'b1, OFF_COUNT, 32'h90);
		bus(1'b1, OFF_TXDATA, 32'h35A);
		i_peer.uartSpike();
		repeat (40) @(posedge ref_clk);
		bus(1'b0, OFF_STATUS, 32'h0);
		`CHK("spike ignored", 1'b0, q[ST_RX_FLAG])
		fork
			i_peer.uartSend(8'hC3, 1'b1);
			bus(1'b1, OFF_CMD, 32'(1 << CMD_START));
		join
		poll(ST_CLK_ACTIVE, 1'b0);
		`CHK("uart tx", 9'h15A, i_peer.uCap)
		poll(ST_RX_FLAG, 1'b1);
		bus(1'b0, OFF_RXDATA, 32'h0);
		`CHK("uart rx", 8'hC3, q[7:0])
		bus(1'b1, OFF_CMD, 32'(1 << CMD_FLAGCLR));
		bus(1'b0, OFF_STATUS, 32'h0);
		`CHK("flag clear", 1'b0, q[ST_RX_FLAG])
		// Second frame only after a full stop bit of quiet line
		bus(1'b1, OFF_TXDATA, 32'h1A5);
		repeat (16) @(posedge ref_clk);
		bus(1'b1, OFF_CMD, 32'(1 << CMD_START));
		poll(ST_CLK_ACTIVE, 1'b0);
		`CHK("uart tx again", 9'h1A5, i_peer.uCap)
		end_sim();
	end
endmodule : msp_top_bench
`default_nettype wire
